// ---- core/shift_scale_pkg.sv ----
// constants and carriers shared by the shift, scale and arithmetic unit
// Overview of operation
// - count is sign-extended index plus count field
// - sum sign picks direction, low six bits
// - right shifts use complemented low six bits
// - single left shift rotates modulo 24
// - single right shift is arithmetic, end-off
// - pair left shift rotates modulo 48
// - pair right shift is arithmetic, end-off
// - arithmetic opcodes decoded as octal 30..63
// - scale rotates pair until bits 47,46 differ
// - scaling a zero pair takes 48 shifts
// - residue is factor minus shifts, to index
// - add storage word into accumulator
// - replace-add stores sum, accumulator unchanged
// - subtract storage word from accumulator
// - double ops use M high, M+1 low
// - multiply: product high aux, low accumulator
// - divide pair: quotient acc, remainder aux
// - single divide fault ends, advances sequencer
// - double multiply: product over pair, extension
// - double divide: quotient pair, remainder extension
// - double divide fault advances sequencer
// - float add rounds on like signs, normalizes, lost bits extension
package shift_scale_pkg;
  localparam int WORD_W = 24;
  localparam int PAIR_W = 48;
  localparam int IDX_W = 15;
  localparam logic [6:0] SCALE_SHIFTS = 7'h30;
  localparam logic [5:0] SINGLE_ROT = 6'h18;
  localparam logic [5:0] PAIR_ROT = 6'h30;
  localparam logic [5:0] SINGLE_FILL = 6'h17;
  localparam logic [5:0] PAIR_FILL = 6'h2F;
  localparam logic [14:0] ADDR_STEP = 15'h0001;
  localparam logic [5:0] OP_SHIFT_ONE = 6'h0A;
  localparam logic [5:0] OP_SHIFT_PAIR = 6'h0B;
  localparam logic [5:0] OP_ADD = 6'h18;
  localparam logic [5:0] OP_SUB = 6'h19;
  localparam logic [5:0] OP_ADD_D = 6'h1A;
  localparam logic [5:0] OP_SUB_D = 6'h1B;
  localparam logic [5:0] OP_RADD = 6'h1C;
  localparam logic [5:0] OP_MUL = 6'h28;
  localparam logic [5:0] OP_DIV = 6'h29;
  localparam logic [5:0] OP_MUL_D = 6'h2E;
  localparam logic [5:0] OP_DIV_D = 6'h2F;
  localparam logic [5:0] OP_FADD = 6'h30;
  localparam logic [5:0] OP_FSUB = 6'h31;
  localparam logic [5:0] OP_FMUL = 6'h32;
  localparam logic [5:0] OP_FDIV = 6'h33;
  localparam int F_SIGN = 47;
  localparam int F_EXP_HI = 46;
  localparam int F_EXP_LO = 36;
  localparam int F_EXP_W = 11;
  localparam int F_COEF_W = 36;
  typedef struct packed {
    logic [5:0] op;
    logic mode;
    logic [1:0] idx;
    logic [IDX_W-1:0] field;
  } instr_s;
  typedef struct packed {
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] q;
    logic [PAIR_W-1:0] e;
  } regs_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [IDX_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_cmd_s;
  typedef struct packed {
    logic we;
    logic [1:0] sel;
    logic [IDX_W-1:0] data;
  } idx_wr_s;
  typedef logic [2:0][IDX_W-1:0] idx_bank_t;
endpackage

// ---- core/ones_add.sv ----
// ones-complement adder with end-around carry
`timescale 1ns/1ps
`default_nettype none
module ones_add #(
  parameter int W = 24
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] y
);
  logic [W:0] raw;
  assign raw = {1'b0, a} + {1'b0, b};
  assign y = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
endmodule
`default_nettype wire

// ---- core/ones_muldiv.sv ----
// ones-complement multiply and divide on sign and magnitude
`timescale 1ns/1ps
`default_nettype none
module ones_muldiv #(
  parameter int W = 24
) (
  input wire logic [W-1:0] mul_a,
  input wire logic [W-1:0] mul_b,
  input wire logic [2*W-1:0] div_n,
  input wire logic [W-1:0] div_d,
  output logic [2*W-1:0] product,
  output logic [W-1:0] quot,
  output logic [W-1:0] rem,
  output logic fault
);
  logic [W-1:0] ma, mb, dm, dsafe;
  logic [2*W-1:0] pm, nm, qm, rm;
  assign ma = mul_a[W-1] ? ~mul_a : mul_a;
  assign mb = mul_b[W-1] ? ~mul_b : mul_b;
  assign pm = {{W{1'b0}}, ma} * {{W{1'b0}}, mb};
  assign product = (mul_a[W-1] ^ mul_b[W-1]) ? ~pm : pm;
  assign nm = div_n[2*W-1] ? ~div_n : div_n;
  assign dm = div_d[W-1] ? ~div_d : div_d;
  // a zero divisor is replaced so the quotient stays defined
  assign dsafe = (dm == '0) ? {{(W-1){1'b0}}, 1'b1} : dm;
  assign qm = nm / {{W{1'b0}}, dsafe};
  assign rm = nm % {{W{1'b0}}, dsafe};
  assign fault = (dm == '0) || (qm[2*W-1:W-1] != '0);
  assign quot = (div_n[2*W-1] ^ div_d[W-1]) ? ~qm[W-1:0] : qm[W-1:0];
  assign rem = div_n[2*W-1] ? ~rm[W-1:0] : rm[W-1:0];
endmodule
`default_nettype wire

// ---- core/shift_scale_arith_unit.sv ----
// shift, scale and arithmetic execution unit
`timescale 1ns/1ps
`default_nettype none
module shift_scale_arith_unit
  import shift_scale_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire instr_s instr,
  input wire idx_bank_t index_vals,
  input wire logic load_en,
  input wire regs_s load_val,
  input wire logic mem_ack,
  input wire logic [WORD_W-1:0] mem_rdata,
  output var regs_s regs,
  output logic busy,
  output logic done,
  output logic fault,
  output var mem_cmd_s mem,
  output var idx_wr_s idx_wr
);
  typedef enum logic [2:0] {
    S_IDLE, S_DECODE, S_FETCH_HI, S_FETCH_LO, S_EXEC, S_SCALE, S_STORE
  } state_e;

  state_e state;
  instr_s ir;
  logic [WORD_W-1:0] opnd_hi, opnd_lo;
  logic [PAIR_W-1:0] opnd_pair, pair, pair_dbl_hi;
  logic [6:0] scale_cnt;
  logic zero_start;
  logic is_shift, one_word, two_words, scale_op, scale_stop, finishing;
  logic [IDX_W-1:0] idx_val, eff_addr, addr_inc, residue;
  logic [WORD_W-1:0] count_sum, single_src, single_res, add_rhs, sum_single, single_sra;
  logic go_left;
  logic [5:0] amount, amt_single, amt_pair;
  logic [2*WORD_W-1:0] single_dbl, prod_single;
  logic [2*PAIR_W-1:0] pair_dbl, prod_double, fadd_res;
  logic [PAIR_W-1:0] pair_res, dbl_rhs, sum_double, quot_double, rem_double, pair_sra;
  logic [WORD_W-1:0] quot_single, rem_single;
  logic fault_single, fault_double;

  // only the exponents of both operands are compared, on magnitudes; coefficients are not compared
  function automatic logic [2*PAIR_W-1:0] float_add(
    input logic [PAIR_W-1:0] x,
    input logic [PAIR_W-1:0] y
  );
    logic [PAIR_W-1:0] mx, my, big, sml, mag;
    logic sb, ss, sr;
    logic [F_EXP_W-1:0] eb, d;
    logic [2*F_COEF_W:0] al;
    logic [F_COEF_W+1:0] r;
    logic [F_EXP_W:0] er;
    mx = x[F_SIGN] ? ~x : x;
    my = y[F_SIGN] ? ~y : y;
    if (mx[F_EXP_HI:F_EXP_LO] >= my[F_EXP_HI:F_EXP_LO]) begin
      big = mx;
      sml = my;
      sb = x[F_SIGN];
      ss = y[F_SIGN];
    end else begin
      big = my;
      sml = mx;
      sb = y[F_SIGN];
      ss = x[F_SIGN];
    end
    eb = big[F_EXP_HI:F_EXP_LO];
    d = eb - sml[F_EXP_HI:F_EXP_LO];
    al = {1'b0, sml[F_COEF_W-1:0], {F_COEF_W{1'b0}}} >> d;
    if (sb == ss) begin
      // round by adding the first bit lost in alignment
      r = {2'b00, big[F_COEF_W-1:0]} + {1'b0, al[2*F_COEF_W:F_COEF_W]}
        + {{(F_COEF_W+1){1'b0}}, al[F_COEF_W-1]};
    end else begin
      r = {2'b00, big[F_COEF_W-1:0]} - {1'b0, al[2*F_COEF_W:F_COEF_W]};
    end
    sr = sb;
    if (r[F_COEF_W+1]) begin
      r = -r;
      sr = ~sb;
    end
    er = {1'b0, eb};
    if (r[F_COEF_W]) begin
      r = r >> 1;
      er = er + 12'h001;
    end
    for (int i = 0; i < F_COEF_W; i++) begin
      if (r != '0 && !r[F_COEF_W-1]) begin
        r = r << 1;
        er = er - 12'h001;
      end
    end
    mag = (r == '0) ? '0 : {1'b0, er[F_EXP_W-1:0], r[F_COEF_W-1:0]};
    float_add = {sr ? ~mag : mag, al[F_COEF_W-1:0], {(PAIR_W-F_COEF_W){1'b0}}};
  endfunction

  // decode
  assign is_shift = (ir.op == OP_SHIFT_ONE) || (ir.op == OP_SHIFT_PAIR);
  assign one_word = ir.op inside {OP_ADD, OP_SUB, OP_RADD, OP_MUL, OP_DIV};
  assign two_words = ir.op inside {OP_ADD_D, OP_SUB_D, OP_MUL_D, OP_DIV_D,
    OP_FADD, OP_FSUB, OP_FMUL, OP_FDIV};
  assign scale_op = (ir.op == OP_SHIFT_PAIR) && ir.mode;
  assign idx_val = (ir.idx == 2'h0) ? '0 : index_vals[ir.idx - 2'h1];
  assign pair = {regs.a, regs.q};
  assign opnd_pair = {opnd_hi, opnd_lo};

  ones_add #(.W(IDX_W)) u_addr (
    .a(ir.field),
    .b(idx_val),
    .y(eff_addr)
  );
  // M+1 wraps in ones complement like the address path
  ones_add #(.W(IDX_W)) u_addr_inc (
    .a(mem.addr),
    .b(ADDR_STEP),
    .y(addr_inc)
  );

  // shift count: both halves sign-extended even with no index
  ones_add #(.W(WORD_W)) u_count (
    .a({{(WORD_W-IDX_W){idx_val[IDX_W-1]}}, idx_val}),
    .b({{(WORD_W-IDX_W){ir.field[IDX_W-1]}}, ir.field}),
    .y(count_sum)
  );
  assign go_left = ~count_sum[WORD_W-1];
  assign amount = go_left ? count_sum[5:0] : ~count_sum[5:0];
  assign amt_single = amount % SINGLE_ROT;
  assign amt_pair = (amount >= PAIR_ROT) ? amount - PAIR_ROT : amount;
  assign single_src = ir.mode ? regs.q : regs.a;
  assign single_dbl = {single_src, single_src} << amt_single;
  // right shifts stand alone: inside an unsigned ternary they would lose the sign fill
  assign single_sra = $signed(single_src) >>> amount;
  assign single_res = go_left ? single_dbl[2*WORD_W-1:WORD_W]
    : single_sra;
  assign pair_dbl = {pair, pair} << amt_pair;
  assign pair_dbl_hi = pair_dbl[2*PAIR_W-1:PAIR_W];
  assign pair_sra = $signed(pair) >>> amount;
  assign pair_res = go_left ? pair_dbl_hi : pair_sra;

  // fixed-point add and subtract
  assign add_rhs = (ir.op == OP_SUB) ? ~opnd_hi : opnd_hi;
  ones_add #(.W(WORD_W)) u_add_single (
    .a(regs.a),
    .b(add_rhs),
    .y(sum_single)
  );
  assign dbl_rhs = (ir.op == OP_SUB_D) ? ~opnd_pair : opnd_pair;
  ones_add #(.W(PAIR_W)) u_add_double (
    .a(pair),
    .b(dbl_rhs),
    .y(sum_double)
  );

  ones_muldiv #(.W(WORD_W)) u_md_single (
    .mul_a(regs.a),
    .mul_b(opnd_hi),
    .div_n(pair),
    .div_d(opnd_hi),
    .product(prod_single),
    .quot(quot_single),
    .rem(rem_single),
    .fault(fault_single)
  );
  ones_muldiv #(.W(PAIR_W)) u_md_double (
    .mul_a(pair),
    .mul_b(opnd_pair),
    .div_n({pair, regs.e}),
    .div_d(opnd_pair),
    .product(prod_double),
    .quot(quot_double),
    .rem(rem_double),
    .fault(fault_double)
  );
  assign fadd_res = float_add(pair, opnd_pair);

  // scale ends on differing top bits or after a full turn
  assign scale_stop = (scale_cnt == SCALE_SHIFTS)
    || (!zero_start && (regs.a[WORD_W-1] != regs.a[WORD_W-2]));
  ones_add #(.W(IDX_W)) u_residue (
    .a(ir.field),
    .b(~{8'h00, scale_cnt}),
    .y(residue)
  );

  assign finishing = (state == S_DECODE && !is_shift && !one_word && !two_words)
    || (state == S_EXEC && !scale_op && ir.op != OP_RADD)
    || (state == S_SCALE && scale_stop)
    || (state == S_STORE && mem_ack);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: if (start) state <= S_DECODE;
        S_DECODE: begin
          if (is_shift) state <= S_EXEC;
          else if (one_word || two_words) state <= S_FETCH_HI;
          else state <= S_IDLE;
        end
        S_FETCH_HI: if (mem_ack) state <= two_words ? S_FETCH_LO : S_EXEC;
        S_FETCH_LO: if (mem_ack) state <= S_EXEC;
        S_EXEC: begin
          if (scale_op) state <= S_SCALE;
          else if (ir.op == OP_RADD) state <= S_STORE;
          else state <= S_IDLE;
        end
        S_SCALE: if (scale_stop) state <= S_IDLE;
        S_STORE: if (mem_ack) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ir <= '0;
      opnd_hi <= '0;
      opnd_lo <= '0;
    end else begin
      if (state == S_IDLE && start) ir <= instr;
      if (state == S_FETCH_HI && mem_ack) opnd_hi <= mem_rdata;
      if (state == S_FETCH_LO && mem_ack) opnd_lo <= mem_rdata;
    end
  end

  // sequencer handshake; a divide fault ends the instruction at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      fault <= 1'b0;
    end else begin
      busy <= (state == S_IDLE) ? start : !finishing;
      done <= finishing;
      fault <= (state == S_EXEC) && ((ir.op == OP_DIV && fault_single)
        || (ir.op == OP_DIV_D && fault_double));
    end
  end

  // storage port: request held until acknowledged
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem <= '0;
    end else begin
      case (state)
        S_DECODE: begin
          if (one_word || two_words) begin
            mem.req <= 1'b1;
            mem.we <= 1'b0;
            mem.addr <= eff_addr;
          end
        end
        S_FETCH_HI: begin
          if (mem_ack && two_words) mem.addr <= addr_inc;
          else if (mem_ack) mem.req <= 1'b0;
        end
        S_FETCH_LO: if (mem_ack) mem.req <= 1'b0;
        S_EXEC: begin
          if (ir.op == OP_RADD) begin
            mem.req <= 1'b1;
            mem.we <= 1'b1;
            mem.wdata <= sum_single;
          end
        end
        S_STORE: begin
          if (mem_ack) begin
            mem.req <= 1'b0;
            mem.we <= 1'b0;
          end
        end
        default: mem.req <= 1'b0;
      endcase
    end
  end

  // accumulator, auxiliary and extension registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regs <= '0;
    end else if (state == S_IDLE && load_en) begin
      regs <= load_val;
    end else if (state == S_EXEC) begin
      case (ir.op)
        OP_SHIFT_ONE: begin
          if (ir.mode) regs.q <= single_res;
          else regs.a <= single_res;
        end
        OP_SHIFT_PAIR: if (!ir.mode) {regs.a, regs.q} <= pair_res;
        OP_ADD, OP_SUB: regs.a <= sum_single;
        OP_ADD_D, OP_SUB_D: {regs.a, regs.q} <= sum_double;
        OP_MUL: {regs.q, regs.a} <= prod_single;
        OP_DIV: begin
          // contents after a fault are left as they were
          if (!fault_single) begin
            regs.a <= quot_single;
            regs.q <= rem_single;
          end
        end
        OP_MUL_D: {regs.a, regs.q, regs.e} <= prod_double;
        OP_DIV_D: begin
          if (!fault_double) begin
            {regs.a, regs.q} <= quot_double;
            regs.e <= rem_double;
          end
        end
        OP_FADD: {regs.a, regs.q, regs.e} <= fadd_res;
        default: regs <= regs;
      endcase
    end else if (state == S_SCALE && !scale_stop) begin
      {regs.a, regs.q} <= {pair[PAIR_W-2:0], pair[PAIR_W-1]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scale_cnt <= '0;
      zero_start <= 1'b0;
    end else if (state == S_EXEC) begin
      scale_cnt <= '0;
      zero_start <= (pair == '0) || (pair == '1);
    end else if (state == S_SCALE && !scale_stop) begin
      scale_cnt <= scale_cnt + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idx_wr <= '0;
    end else begin
      idx_wr.we <= (state == S_SCALE) && scale_stop && (ir.idx != 2'h0);
      if (state == S_SCALE && scale_stop) begin
        idx_wr.sel <= ir.idx;
        idx_wr.data <= residue;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_single_turn;
    state == S_EXEC && ir.op == OP_SHIFT_ONE && !ir.mode && go_left
      && amount == SINGLE_ROT |=> regs.a == $past(regs.a);
  endproperty
  a_single_turn: assert property (p_single_turn)
    else $error("left shift by 24 changed the accumulator");

  property p_single_fill;
    state == S_EXEC && ir.op == OP_SHIFT_ONE && !ir.mode && !go_left
      && amount >= SINGLE_FILL |=> regs.a == {WORD_W{$past(regs.a[WORD_W-1])}};
  endproperty
  a_single_fill: assert property (p_single_fill)
    else $error("long right shift did not fill with sign");

  property p_pair_turn;
    state == S_EXEC && ir.op == OP_SHIFT_PAIR && !ir.mode && go_left
      && amount == PAIR_ROT |=> pair == $past(pair);
  endproperty
  a_pair_turn: assert property (p_pair_turn)
    else $error("left shift by 48 changed the pair");

  property p_pair_fill;
    state == S_EXEC && ir.op == OP_SHIFT_PAIR && !ir.mode && !go_left
      && amount >= PAIR_FILL |=> pair == {PAIR_W{$past(regs.a[WORD_W-1])}};
  endproperty
  a_pair_fill: assert property (p_pair_fill)
    else $error("long pair right shift did not fill with sign");

  property p_scale_stop;
    state == S_SCALE && !zero_start && regs.a[WORD_W-1] != regs.a[WORD_W-2]
      |=> state == S_IDLE && done && $stable(pair);
  endproperty
  a_scale_stop: assert property (p_scale_stop)
    else $error("scale kept shifting after normalizing");

  property p_zero_scale;
    state == S_SCALE && zero_start && scale_stop |-> scale_cnt == SCALE_SHIFTS;
  endproperty
  a_zero_scale: assert property (p_zero_scale)
    else $error("zero pair not scaled exactly 48 times");

  property p_residue;
    idx_wr.we |-> idx_wr.sel == ir.idx && ir.idx != 2'h0 && $past(state) == S_SCALE;
  endproperty
  a_residue: assert property (p_residue)
    else $error("residue written to wrong index register");

  property p_replace;
    state == S_EXEC && ir.op == OP_RADD
      |=> mem.req && mem.we && mem.wdata == $past(sum_single) && regs.a == $past(regs.a);
  endproperty
  a_replace: assert property (p_replace)
    else $error("replace-add did not store sum or changed accumulator");

  property p_add;
    state == S_EXEC && (ir.op == OP_ADD || ir.op == OP_SUB) |=> regs.a == $past(sum_single);
  endproperty
  a_add: assert property (p_add)
    else $error("accumulator add or subtract result wrong");

  property p_fault;
    state == S_EXEC && ir.op == OP_DIV && fault_single |=> fault && done && !busy;
  endproperty
  a_fault: assert property (p_fault)
    else $error("divide fault did not end the instruction");

  property p_second_word;
    state == S_FETCH_HI && mem_ack && two_words |=> mem.req && mem.addr == $past(addr_inc);
  endproperty
  a_second_word: assert property (p_second_word)
    else $error("second operand word not requested at M+1");

  c_scale: cover property (state == S_SCALE && scale_stop && ir.idx != 2'h0);
  c_fault: cover property (fault);
  c_replace: cover property (state == S_STORE && mem_ack);
  c_float: cover property (state == S_EXEC && ir.op == OP_FADD);
endmodule
`default_nettype wire

// ---- verification/core_store_model.sv ----
// core storage model answering the unit's word requests after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module core_store_model
  import shift_scale_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire mem_cmd_s mem,
  input wire logic [1:0] lag,
  output logic mem_ack,
  output logic [WORD_W-1:0] mem_rdata
);
  // plain always: the bench preloads words here between instructions
  logic [WORD_W-1:0] store [0:32767];
  logic [1:0] wait_cnt;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'h0;
      wait_cnt <= 2'h0;
      mem_rdata <= 24'hA5A5A5;
    end else if (mem_ack || !mem.req) begin
      // read data is only good in the ack cycle, so it toggles otherwise
      mem_ack <= 1'h0;
      wait_cnt <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_cnt >= lag) begin
      mem_ack <= 1'h1;
      mem_rdata <= store[mem.addr];
      if (mem.we) begin
        store[mem.addr] <= mem.wdata;
      end
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- verification/shift_scale_arith_unit_tb_top.sv ----
// self-checking testbench for the shift, scale and arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module shift_scale_arith_unit_tb_top
  import shift_scale_pkg::*;
;
  logic clock, arst_n, start, load_en, mem_ack, busy, done, fault;
  logic [1:0] lag;
  logic [WORD_W-1:0] mem_rdata;
  instr_s instr;
  idx_bank_t index_vals;
  regs_s load_val, regs, r, x;
  mem_cmd_s mem;
  idx_wr_s idx_wr;
  int miscompares, checked;

  shift_scale_arith_unit shift_scale_arith_unit_inst (.clock(clock), .arst_n(arst_n),
    .start(start), .instr(instr), .index_vals(index_vals), .load_en(load_en),
    .load_val(load_val), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .regs(regs), .busy(busy),
    .done(done), .fault(fault), .mem(mem), .idx_wr(idx_wr));
  core_store_model core_store_model_inst (.clock(clock), .arst_n(arst_n), .mem(mem),
    .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] expv);
    checked++;
    if (seen !== expv) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ones-complement sum of w-bit values with end-around carry
  function automatic longint unsigned oadd(int w, longint unsigned a, longint unsigned b);
    longint unsigned m = (64'h1 << w) - 64'h1;
    longint unsigned s = (a & m) + (b & m);
    s = (s & m) + (s >> w);
    return s & m;
  endfunction

  function automatic logic [14:0] bsel(idx_bank_t iv, logic [1:0] ix);
    return ix == 2'h0 ? 15'h0 : iv[ix - 2'h1];
  endfunction

  // sign-magnitude product of two n-bit ones-complement values
  function automatic logic [95:0] smul(int n, logic [47:0] a, logic [47:0] b);
    logic [47:0] m = (48'h1 << n) - 48'h1;
    logic [95:0] pr = 96'(a[n - 1] ? ~a & m : a) * 96'(b[n - 1] ? ~b & m : b);
    return (a[n - 1] ^ b[n - 1]) ? ~pr & ((96'h1 << 2 * n) - 96'h1) : pr;
  endfunction

  function automatic regs_s shift_ref(regs_s s, logic pair, logic md, logic [14:0] f,
      logic [14:0] b);
    logic [23:0] k = 24'(oadd(24, {{9{f[14]}}, f}, {{9{b[14]}}, b}));
    int amt = k[23] ? int'(6'(~k[5:0])) : int'(k[5:0]);
    logic [23:0] w = md ? s.q : s.a;
    logic [95:0] pp;
    if (!pair && !k[23]) begin
      pp = {w, w, 48'h0} << (amt % 24);
      w = pp[95:72];
    end else if (!pair) w = $signed(w) >>> amt;
    if (!pair && md) s.q = w;
    else if (!pair) s.a = w;
    else if (!k[23]) begin
      pp = {s.a, s.q, s.a, s.q} << (amt >= 48 ? amt - 48 : amt);
      {s.a, s.q} = pp[95:48];
    end else {s.a, s.q} = $signed({s.a, s.q}) >>> amt;
    return s;
  endfunction

  task automatic run(input regs_s s, input logic [5:0] op, input logic md, input logic [1:0] ix,
      input logic [14:0] f, input idx_bank_t iv);
    int n;
    @(posedge clock);
    load_en <= 1'h1;
    load_val <= s;
    index_vals <= iv;
    lag <= 2'($urandom);
    @(posedge clock);
    load_en <= 1'h0;
    start <= 1'h1;
    instr <= '{op, md, ix, f};
    @(posedge clock);
    start <= 1'h0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'h1 && n < 500);
    if (n >= 500) begin
      miscompares++;
      results();
    end
  endtask

  initial begin
    idx_bank_t iv;
    logic [14:0] f, m;
    logic [1:0] ix;
    logic [23:0] y, d, qt, rm;
    logic [47:0] p, v;
    int n;
    logic [14:0] bnd [4] = '{15'h0018, 15'h0030, 15'h7FE8, 15'h7FD0};
    logic [5:0] ops [8] = '{OP_ADD, OP_SUB, OP_RADD, OP_ADD_D, OP_SUB_D, OP_MUL, OP_DIV,
      OP_MUL_D};
    logic [5:0] other [6] = '{OP_FSUB, OP_FMUL, OP_FDIV, 6'h3F, OP_FADD, OP_DIV_D};
    miscompares = 0;
    checked = 0;
    arst_n = 1'h0;
    start = 1'h0;
    load_en = 1'h0;
    lag = 2'h0;
    instr = '0;
    index_vals = '0;
    load_val = '0;
    void'($urandom(60221));
    repeat (20) @(posedge clock);
    arst_n <= 1'h1;
    check("regs after reset", regs, 96'h0);
    // first four use the boundary counts: left 24, left 48, right 23, right 47
    for (int i = 0; i < 60; i++) begin
      r = 96'({$urandom, $urandom, $urandom});
      iv = 45'({$urandom, $urandom});
      ix = i < 4 ? 2'h0 : 2'($urandom);
      f = i < 4 ? bnd[i] : 15'($urandom);
      x = shift_ref(r, i[0], ~i[0] & i[1], f, bsel(iv, ix));
      run(r, i[0] ? OP_SHIFT_PAIR : OP_SHIFT_ONE, ~i[0] & i[1], ix, f, iv);
      check("shift regs", regs, x);
    end
    for (int i = 0; i < 6; i++) begin
      p = i == 0 ? 48'h0 : 48'({$urandom, $urandom}) >> (i * 9 - 9);
      r = 96'({p, 48'h0});
      {r.a, r.q} = i[0] ? ~p : p;
      p = {r.a, r.q};
      n = 0;
      while (n < 48 && p[47] == p[46]) begin
        p = {p[46:0], p[47]};
        n++;
      end
      f = 15'($urandom);
      ix = 2'(i);
      run(r, OP_SHIFT_PAIR, 1'h1, ix, f, iv);
      check("scaled pair", {regs.a, regs.q}, p);
      check("residue strobe", idx_wr.we, ix != 2'h0);
      if (ix != 2'h0) check("residue", {idx_wr.sel, idx_wr.data}, {ix, 15'(oadd(15, f, ~n))});
    end
    for (int i = 0; i < 24; i++) begin
      r = 96'({$urandom, $urandom, $urandom});
      iv = 45'({$urandom, $urandom});
      ix = i == 3 ? 2'h0 : 2'($urandom);
      f = i == 3 ? 15'h7FFF : 15'($urandom);
      m = 15'(oadd(15, f, bsel(iv, ix)));
      y = 24'($urandom);
      v = {y, 24'($urandom)};
      x = r;
      case (i % 8)
        0: x.a = 24'(oadd(24, r.a, y));
        1: x.a = 24'(oadd(24, r.a, ~y));
        2: p = 48'(oadd(24, r.a, y));
        3: {x.a, x.q} = 48'(oadd(48, {r.a, r.q}, v));
        4: {x.a, x.q} = 48'(oadd(48, {r.a, r.q}, ~v));
        5: {x.q, x.a} = 48'(smul(24, r.a, y));
        6: begin
          // divisor magnitude of at least 2^22 keeps the quotient in range
          y[22] = ~y[23];
          p = 48'({$urandom, $urandom}) & 48'h1FFF_FFFF_FFFF;
          {r.a, r.q} = r.e[0] ? ~p : p;
          d = y[23] ? ~y : y;
          qt = 24'(p / d);
          rm = 24'(p % d);
          x = r;
          x.a = (r.e[0] ^ y[23]) ? ~qt : qt;
          x.q = r.e[0] ? ~rm : rm;
        end
        default: x = smul(48, {r.a, r.q}, v);
      endcase
      core_store_model_inst.store[m] = y;
      core_store_model_inst.store[15'(oadd(15, m, 1))] = v[23:0];
      run(r, ops[i % 8], 1'h0, ix, f, iv);
      check("arith regs", regs, x);
      if (i % 8 == 2) check("stored sum", core_store_model_inst.store[m], p);
      if (i % 8 == 6) check("divide fault", fault, 1'h0);
    end
    for (int i = 0; i < 3; i++) begin
      r = 96'({$urandom, $urandom, $urandom});
      core_store_model_inst.store[15'h0100] = i == 1 ? 24'hFFFFFF : 24'h0;
      core_store_model_inst.store[15'h0101] = 24'h0;
      run(r, i == 2 ? OP_DIV_D : OP_DIV, 1'h0, 2'h0, 15'h0100, iv);
      check("fault flag", fault, 1'h1);
      check("fault regs", regs, r);
    end
    core_store_model_inst.store[15'h0200] = 24'($urandom);
    core_store_model_inst.store[15'h0201] = 24'($urandom);
    foreach (other[j]) begin
      run(r, other[j], 1'h0, 2'h0, 15'h0200, iv);
      if (j < 4) check("unchanged regs", regs, r);
      r = regs;
    end
    // adding positive zero to a normalized value gives it back, nothing lost to E
    r = 96'({$urandom, $urandom, $urandom});
    r.a = (r.a & 24'h7FFFFF) | 24'h000800;
    core_store_model_inst.store[15'h0300] = 24'h0;
    core_store_model_inst.store[15'h0301] = 24'h0;
    run(r, OP_FADD, 1'h0, 2'h0, 15'h0300, iv);
    check("float add zero", regs, {r.a, r.q, 48'h0});
    results();
  end
endmodule
`default_nettype wire
